// ===== fpp_cfg.svh
// fpp_cfg.svh: constants for the four-phase instruction pipeline control block
// assumes inclusion by bare name from the package and the design modules
`ifndef FPP_CFG_SVH
`define FPP_CFG_SVH

// ---------------------------------------------------------------------------
// phase and datapath figures
// ---------------------------------------------------------------------------
`define FPP_PHASES        4
`define FPP_PHASE_W       2
`define FPP_PHASE_FETCH   2'h0
`define FPP_PHASE_LAST    2'h3
`define FPP_DATA_W        8
`define FPP_PC_W          13
`define FPP_PAGE_W        8
`define FPP_INSTR_W       16

`endif

// ===== fpp_pkg.sv
// fpp_pkg.sv: types shared by the pipeline control modules
// assumes fpp_cfg.svh is on the include path
`include "fpp_cfg.svh"

package fpp_pkg;

    // ---------------------------------------------------------------------------
    // alu operations
    // ---------------------------------------------------------------------------
    typedef enum logic [2:0] {
        FPP_ALU_PASS,
        FPP_ALU_ADD,
        FPP_ALU_SUB,
        FPP_ALU_AND,
        FPP_ALU_OR,
        FPP_ALU_XOR,
        FPP_ALU_INC,
        FPP_ALU_DEC
    } fpp_alu_op_t;

    // instruction class as seen by the sequencer
    typedef enum logic [2:0] {
        FPP_CLS_PLAIN,
        FPP_CLS_JUMP,
        FPP_CLS_CALL,
        FPP_CLS_SKIP,
        FPP_CLS_PCLWR
    } fpp_class_t;

endpackage : fpp_pkg

// ===== fpp_alu_if.sv
// fpp_alu_if.sv: carrier between the sequencer and the 8-bit alu
// assumes both ends share clk_sys
`timescale 1ns/1ps
`include "fpp_cfg.svh"

interface fpp_alu_if;
    logic                        strobe;
    fpp_pkg::fpp_alu_op_t        op;
    logic [`FPP_DATA_W-1:0]      operand;
    logic [`FPP_DATA_W-1:0]      acc;
    logic                        zero;

    modport seq (output strobe, output op, output operand, input acc, input zero);
    modport alu (input strobe, input op, input operand, output acc, output zero);
endinterface : fpp_alu_if

// ===== fpp_alu.sv
// fpp_alu.sv: single 8-bit alu with the accumulator held in its register
// assumes operations are strobed once per instruction cycle in the fetch phase
`timescale 1ns/1ps
`include "fpp_cfg.svh"

module fpp_alu (
    // clock and reset
    input  wire logic clk_sys,
    input  wire logic reset,
    // datapath carrier
    fpp_alu_if.alu    bus
);

    typedef struct packed {
        logic [`FPP_DATA_W-1:0] acc;
    } fpp_alu_state_t;

    fpp_alu_state_t st_r;
    fpp_alu_state_t st_nxt;

    // ---------------------------------------------------------------------------
    // accumulator update: every result routes back through the accumulator
    // ---------------------------------------------------------------------------
    always_comb begin
        st_nxt = st_r;
        if (bus.strobe) begin
            unique case (bus.op)
                fpp_pkg::FPP_ALU_PASS: st_nxt.acc = bus.operand;
                fpp_pkg::FPP_ALU_ADD:  st_nxt.acc = st_r.acc + bus.operand;
                fpp_pkg::FPP_ALU_SUB:  st_nxt.acc = st_r.acc - bus.operand;
                fpp_pkg::FPP_ALU_AND:  st_nxt.acc = st_r.acc & bus.operand;
                fpp_pkg::FPP_ALU_OR:   st_nxt.acc = st_r.acc | bus.operand;
                fpp_pkg::FPP_ALU_XOR:  st_nxt.acc = st_r.acc ^ bus.operand;
                fpp_pkg::FPP_ALU_INC:  st_nxt.acc = bus.operand + 8'h01;
                fpp_pkg::FPP_ALU_DEC:  st_nxt.acc = bus.operand - 8'h01;
            endcase
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign bus.acc  = st_r.acc;
    assign bus.zero = (st_r.acc == 8'h00);

endmodule : fpp_alu

// ===== fpp_pipeline.sv
// fpp_pipeline.sv: four-phase instruction timing and pipeline sequencer
// assumes program memory answers a fetch address within the fetch phase,
// and the decoder outside classifies the latched instruction combinationally
//
// Operation
// - four non-overlapping phases from the system clock form one instruction cycle
// - program counter increments at fetch phase start; instruction fetched that phase
// - decode and execute occupy phases two to four
// - next fetch overlaps current execute; one instruction per cycle
// - jumps and calls take three cycles: get target, branch, then fetch target
// - rc mode drives fetch-phase clock on spare pin, quarter rate, 1:3
// - one 8-bit alu, data routed through the accumulator
// - taken skip discards prefetched instruction, inserts a dummy cycle
// - program counter low byte write jumps within page, two dummy cycles
`timescale 1ns/1ps
`include "fpp_cfg.svh"

module fpp_pipeline #(
    parameter int PC_W = `FPP_PC_W
) (
    // clock and reset
    input  wire logic                     clk_sys,
    input  wire logic                     reset,
    // option strap
    input  wire logic                     rcOscMode,
    // program memory
    input  wire logic [`FPP_INSTR_W-1:0]  fetchData,
    output logic      [PC_W-1:0]          fetchAddr,
    output logic                          fetchStrobe,
    // decoder view of the latched instruction
    input  wire fpp_pkg::fpp_class_t      instrClass,
    input  wire logic [PC_W-1:0]          branchTarget,
    input  wire logic                     skipCond,
    input  wire fpp_pkg::fpp_alu_op_t     aluOp,
    input  wire logic [`FPP_DATA_W-1:0]   aluOperand,
    input  wire logic [`FPP_DATA_W-1:0]   pclWriteData,
    // execute view
    output logic      [`FPP_INSTR_W-1:0]  execInstr,
    output logic                          execValid,
    output logic      [`FPP_PHASES-1:0]   phaseOneHot,
    output logic      [`FPP_DATA_W-1:0]   accValue,
    // spare oscillator output pin
    output logic                          spareOscOut,
    output logic                          spareOscOe
);

    typedef enum logic [1:0] {
        FPP_RUN,
        FPP_BRANCH,
        FPP_DUMMY
    } fpp_seq_t;

    typedef struct packed {
        logic [`FPP_PHASE_W-1:0]  phase;
        fpp_seq_t                 seq;
        logic [PC_W-1:0]          pc;
        logic [PC_W-1:0]          target;
        logic [`FPP_INSTR_W-1:0]  fetched;
        logic                     fetchedValid;
        logic [`FPP_INSTR_W-1:0]  exec;
        logic                     execValid;
        logic [`FPP_PHASES-1:0]   phaseOneHot;
        logic [PC_W-1:0]          fetchAddr;
        logic                     fetchStrobe;
        logic                     oscOut;
        logic                     oscOe;
        logic                     aluStrobe;
        fpp_pkg::fpp_alu_op_t     aluOp;
        logic [`FPP_DATA_W-1:0]   aluOperand;
    } fpp_state_t;

    fpp_state_t st_r;
    fpp_state_t st_nxt;

    fpp_alu_if aluBus ();

    // ---------------------------------------------------------------------------
    // the single datapath alu
    // ---------------------------------------------------------------------------
    fpp_alu uAlu (
        .clk_sys (clk_sys),
        .reset   (reset),
        .bus     (aluBus.alu)
    );

    assign aluBus.strobe  = st_r.aluStrobe;
    assign aluBus.op      = st_r.aluOp;
    assign aluBus.operand = st_r.aluOperand;

    // ---------------------------------------------------------------------------
    // next-state logic
    // ---------------------------------------------------------------------------
    logic [`FPP_PHASE_W-1:0] phaseNext;
    logic                    endOfCycle;

    always_comb begin
        st_nxt     = st_r;
        phaseNext  = st_r.phase + 2'h1;
        endOfCycle = (st_r.phase == `FPP_PHASE_LAST);
        st_nxt.phase     = phaseNext;
        st_nxt.aluStrobe = 1'b0;
        st_nxt.fetchStrobe = 1'b0;

        // registered one-hot phase view, matching the phase about to start
        for (int i = 0; i < `FPP_PHASES; i++) begin
            st_nxt.phaseOneHot[i] = (phaseNext == i[`FPP_PHASE_W-1:0]);
        end

        // quarter-rate strobe high for the fetch phase only, giving 1:3
        st_nxt.oscOe  = rcOscMode;
        st_nxt.oscOut = rcOscMode && (phaseNext == `FPP_PHASE_FETCH);

        // fetch phase opens: present the pc to program memory and bump it
        if (endOfCycle) begin
            st_nxt.pc          = st_r.pc + 1'b1;
            st_nxt.fetchAddr   = st_r.pc;
            st_nxt.fetchStrobe = 1'b1;
            // the fetched word moves to execute while the next one loads
            st_nxt.exec      = st_r.fetched;
            // a dummy cycle only blanks the skipped word, so the word after it runs
            st_nxt.execValid = st_r.fetchedValid && (st_r.seq != FPP_BRANCH);
        end

        // instruction in memory is captured during the fetch phase
        if (st_r.fetchStrobe) begin
            st_nxt.fetched      = fetchData;
            st_nxt.fetchedValid = 1'b1;
        end

        // decode late in the cycle, act at its end so phases two to four execute
        if (endOfCycle) begin
            unique case (st_r.seq)
                FPP_RUN: begin
                    if (st_r.execValid) begin
                        st_nxt.aluStrobe  = 1'b0;
                        unique case (instrClass)
                            fpp_pkg::FPP_CLS_JUMP,
                            fpp_pkg::FPP_CLS_CALL: begin
                                // first cycle obtains the target only
                                st_nxt.target = branchTarget;
                                st_nxt.seq    = FPP_BRANCH;
                                st_nxt.execValid = 1'b0;
                            end
                            fpp_pkg::FPP_CLS_SKIP: begin
                                if (skipCond) begin
                                    // drop the prefetched word, pc already past it
                                    st_nxt.seq       = FPP_DUMMY;
                                    st_nxt.execValid = 1'b0;
                                end
                            end
                            fpp_pkg::FPP_CLS_PCLWR: begin
                                // only the low byte changes; the page is that of the current pc,
                                // which is the fetch address, not the one already bumped past it
                                st_nxt.target = {st_r.fetchAddr[PC_W-1:`FPP_PAGE_W],
                                                 pclWriteData};
                                st_nxt.seq       = FPP_BRANCH;
                                st_nxt.execValid = 1'b0;
                            end
                            default: begin
                                st_nxt.aluStrobe  = 1'b1;
                                st_nxt.aluOp      = aluOp;
                                st_nxt.aluOperand = aluOperand;
                            end
                        endcase
                    end
                end
                FPP_BRANCH: begin
                    // second cycle: refetch from the target, old prefetch is stale
                    st_nxt.fetchAddr    = st_r.target;
                    st_nxt.pc           = st_r.target + 1'b1;
                    st_nxt.fetchedValid = 1'b0;
                    st_nxt.seq          = FPP_RUN;
                end
                FPP_DUMMY: begin
                    // dummy cycle executes nothing while the right word loads
                    st_nxt.seq = FPP_RUN;
                end
            endcase
        end
    end

    // ---------------------------------------------------------------------------
    // state register; reset lands on the last phase so the first edge opens fetch
    // ---------------------------------------------------------------------------
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            st_r       <= '0;
            st_r.phase <= `FPP_PHASE_LAST;
            st_r.seq   <= FPP_RUN;
            st_r.pc    <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ---------------------------------------------------------------------------
    // outputs, all but accValue from the state register
    // ---------------------------------------------------------------------------
    assign fetchAddr   = st_r.fetchAddr;
    assign fetchStrobe = st_r.fetchStrobe;
    assign execInstr   = st_r.exec;
    assign execValid   = st_r.execValid;
    assign phaseOneHot = st_r.phaseOneHot;
    assign spareOscOut = st_r.oscOut;
    assign spareOscOe  = st_r.oscOe;

    // accumulator copy kept here so the output is local to this module's flops
    logic [`FPP_DATA_W-1:0] accCopy_r;
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            accCopy_r <= '0;
        end else begin
            accCopy_r <= aluBus.acc;
        end
    end
    assign accValue = accCopy_r;

endmodule : fpp_pipeline

// ===== fpp_pipeline_asserts.sv
// fpp_pipeline_asserts.sv: port-level timing checks for the pipeline sequencer
// assumes it is bound onto fpp_pipeline and sees only that module's ports
`timescale 1ns/1ps
module fpp_pipeline_asserts #(
    parameter int PC_W = 13
) (
    // clock and reset
    input wire logic                 clk_sys,
    input wire logic                 reset,
    // stimulus side
    input wire logic                 rcOscMode,
    input wire fpp_pkg::fpp_class_t  instrClass,
    input wire logic [PC_W-1:0]      branchTarget,
    input wire logic                 skipCond,
    input wire fpp_pkg::fpp_alu_op_t aluOp,
    input wire logic [7:0]           aluOperand,
    input wire logic [7:0]           pclWriteData,
    // design outputs
    input wire logic [PC_W-1:0]      fetchAddr,
    input wire logic                 fetchStrobe,
    input wire logic [15:0]          execInstr,
    input wire logic                 execValid,
    input wire logic [3:0]           phaseOneHot,
    input wire logic [7:0]           accValue,
    input wire logic                 spareOscOut,
    input wire logic                 spareOscOe
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);
    // ---------------------------------------------------------------------------
    // helpers: decode is only taken at the end of a valid last phase
    // ---------------------------------------------------------------------------
    wire logic [3:0]      rotNxt = {phaseOneHot[2:0], phaseOneHot[3]};
    wire logic [PC_W-1:0] pclTgt = {fetchAddr[PC_W-1:8], pclWriteData};
    wire logic            taken  = phaseOneHot[3] && execValid;
    sequence s_redirect(logic [PC_W-1:0] t);
        !execValid ##4 fetchAddr == $past(t, 5);
    endsequence
    property p_rotate; phaseOneHot != 4'h0 |=> phaseOneHot == $past(rotNxt); endproperty
    property p_start; $past(reset) |=> phaseOneHot == 4'h1 && fetchAddr == '0; endproperty
    property p_novalid; $past(reset) |-> !execValid [*4]; endproperty
    property p_strobe; fetchStrobe == phaseOneHot[0]; endproperty
    property p_hold; fetchStrobe |=> $stable(fetchAddr) [*3]; endproperty
    property p_exec; $changed(execInstr) || $changed(execValid) |-> phaseOneHot[0]; endproperty
    property p_plain;
        taken && (instrClass == fpp_pkg::FPP_CLS_PLAIN || (instrClass == fpp_pkg::FPP_CLS_SKIP && !skipCond))
        |=> execValid && fetchAddr == $past(fetchAddr) + 1'h1;
    endproperty
    property p_branch;
        taken && (instrClass == fpp_pkg::FPP_CLS_JUMP || instrClass == fpp_pkg::FPP_CLS_CALL) |=> s_redirect(branchTarget);
    endproperty
    property p_pcl; taken && instrClass == fpp_pkg::FPP_CLS_PCLWR |=> s_redirect(pclTgt); endproperty
    property p_skip;
        taken && instrClass == fpp_pkg::FPP_CLS_SKIP && skipCond
        |=> !execValid && fetchAddr == $past(fetchAddr) + 1'h1 ##4 execValid;
    endproperty
    property p_osc; spareOscOut == (phaseOneHot[0] && spareOscOe); endproperty
    property p_oe; !$past(reset) |-> spareOscOe == $past(rcOscMode); endproperty
    // the accumulator settles well before the next decode edge
    property p_acc;
        taken && instrClass == fpp_pkg::FPP_CLS_PLAIN && aluOp == fpp_pkg::FPP_ALU_ADD
        |-> ##3 accValue == $past(accValue, 3) + $past(aluOperand, 3);
    endproperty
    a_rotate: assert property (p_rotate) else $error("phase did not advance");
    a_start: assert property (p_start) else $error("bad first fetch phase");
    a_novalid: assert property (p_novalid) else $error("valid too early");
    a_strobe: assert property (p_strobe) else $error("strobe off fetch phase");
    a_hold: assert property (p_hold) else $error("fetch address moved");
    a_exec: assert property (p_exec) else $error("execute changed mid cycle");
    a_plain: assert property (p_plain) else $error("plain flow wrong");
    a_branch: assert property (p_branch) else $error("branch wrong");
    a_pcl: assert property (p_pcl) else $error("low byte jump wrong");
    a_skip: assert property (p_skip) else $error("skip wrong");
    a_osc: assert property (p_osc) else $error("spare pin wrong");
    a_oe: assert property (p_oe) else $error("spare enable wrong");
    a_acc: assert property (p_acc) else $error("accumulator wrong");
endmodule // fpp_pipeline_asserts

bind fpp_pipeline fpp_pipeline_asserts #(.PC_W(PC_W)) i_asserts (.clk_sys(clk_sys), .reset(reset),
    .rcOscMode(rcOscMode), .instrClass(instrClass), .branchTarget(branchTarget), .skipCond(skipCond),
    .aluOp(aluOp), .aluOperand(aluOperand), .pclWriteData(pclWriteData), .fetchAddr(fetchAddr),
    .fetchStrobe(fetchStrobe), .execInstr(execInstr), .execValid(execValid), .phaseOneHot(phaseOneHot),
    .accValue(accValue), .spareOscOut(spareOscOut), .spareOscOe(spareOscOe));

// ===== testbench.sv
// testbench.sv: random instruction stream against the pipeline sequencer
// assumes the package and the bound checker are compiled first
`timescale 1ns/1ps
module testbench;
    logic                 clk_sys = 1'h0;
    logic                 reset = 1'h1;
    logic                 rcOscMode = 1'h1;
    logic [15:0]          fetchData = 16'h0;
    fpp_pkg::fpp_class_t  instrClass = fpp_pkg::FPP_CLS_PLAIN;
    logic [12:0]          branchTarget = 13'h0;
    logic                 skipCond = 1'h0;
    fpp_pkg::fpp_alu_op_t aluOp = fpp_pkg::FPP_ALU_PASS;
    logic [7:0]           aluOperand = 8'h0;
    logic [7:0]           pclWriteData = 8'h0;
    logic [12:0]          fetchAddr, lastAddr, tgt, prevExp;
    logic [15:0]          execInstr, e;
    logic [3:0]           phaseOneHot;
    logic [7:0]           accValue;
    logic                 fetchStrobe, execValid, spareOscOut, spareOscOe, pend;
    logic [15:0]          expQ[$]; // evCare, ev, addrCare, addr
    int                   n_mismatch = 0;
    int                   checked = 0;
    fpp_pipeline i_dut (.clk_sys(clk_sys), .reset(reset), .rcOscMode(rcOscMode), .fetchData(fetchData),
        .fetchAddr(fetchAddr), .fetchStrobe(fetchStrobe), .instrClass(instrClass), .branchTarget(branchTarget),
        .skipCond(skipCond), .aluOp(aluOp), .aluOperand(aluOperand), .pclWriteData(pclWriteData),
        .execInstr(execInstr), .execValid(execValid), .phaseOneHot(phaseOneHot), .accValue(accValue),
        .spareOscOut(spareOscOut), .spareOscOe(spareOscOe));
    always #5 clk_sys = ~clk_sys;
    // program memory image: a fixed scramble of the address
    function automatic logic [15:0] word(input logic [12:0] a);
        return {3'h5, a} ^ 16'h0f0f;
    endfunction
    always @(negedge clk_sys) fetchData <= word(fetchAddr);
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic end_of_test();
        $display("checked %0d n_mismatch %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    // ---------------------------------------------------------------------------
    // monitor: each fetch strobe retires the oldest note
    // ---------------------------------------------------------------------------
    always @(posedge clk_sys) begin
        #1;
        if (!reset && fetchStrobe === 1'h1) begin
            if (expQ.size() == 0) check("queue", 16'h1, 16'h0);
            else begin
                e = expQ.pop_front();
                if (e[13]) check("fetchAddr", {3'h0, fetchAddr}, {3'h0, e[12:0]});
                if (e[15]) check("execValid", {15'h0, execValid}, {15'h0, e[14]});
                if (e[15] && e[14]) check("execInstr", execInstr, word(prevExp));
                check("phaseOneHot", {12'h0, phaseOneHot}, 16'h0001);
                check("spareOscOut", {15'h0, spareOscOut}, {15'h0, rcOscMode});
                check("spareOscOe", {15'h0, spareOscOe}, {15'h0, rcOscMode});
                prevExp = e[12:0];
            end
        end
    end
    // one instruction cycle: random decode, even while refused, then model the next fetch
    task automatic step();
        for (int k = 0; k < 8 && phaseOneHot !== 4'h8; k++) @(negedge clk_sys);
        if (phaseOneHot !== 4'h8) begin
            n_mismatch++;
            end_of_test();
        end
        instrClass = fpp_pkg::fpp_class_t'(3'($urandom_range(4, 0)));
        branchTarget = 13'($urandom);
        skipCond = 1'($urandom);
        aluOp = fpp_pkg::fpp_alu_op_t'(3'($urandom));
        aluOperand = 8'($urandom);
        pclWriteData = 8'($urandom);
        if (execValid !== 1'h1 && pend) begin
            expQ.push_back({3'h1, tgt});
            lastAddr = tgt;
            pend = 1'h0;
        end else if (execValid !== 1'h1 || instrClass == fpp_pkg::FPP_CLS_PLAIN) begin
            lastAddr++;
            expQ.push_back({3'h7, lastAddr});
        end else if (instrClass == fpp_pkg::FPP_CLS_SKIP) begin
            lastAddr++;
            expQ.push_back({1'h1, !skipCond, 1'h1, lastAddr});
        end else begin
            tgt = (instrClass == fpp_pkg::FPP_CLS_PCLWR) ? {lastAddr[12:8], pclWriteData} : branchTarget;
            lastAddr++;
            expQ.push_back({3'h4, lastAddr});
            pend = 1'h1;
        end
        @(negedge clk_sys);
    endtask
    task automatic run_test(input string name, input logic mode, input int n);
        reset = 1'h1;
        rcOscMode = mode;
        repeat (5) @(negedge clk_sys);
        expQ.delete();
        pend = 1'h0;
        lastAddr = 13'h0;
        expQ.push_back({3'h5, 13'h0});
        reset = 1'h0;
        repeat (n) step();
        $display("test %s done", name);
    endtask
    initial begin
        void'($urandom(32'hb4cc4d83));
        run_test("rc_on", 1'h1, 80);
        run_test("rc_off_rereset", 1'h0, 80);
        end_of_test();
    end
    // hang guard
    initial begin
        #100000;
        n_mismatch++;
        end_of_test();
    end
endmodule // testbench
